// ===== host_cpu_model.sv
module host_cpu_model (
    input  wire logic                             ref_clk,
    input  wire logic [host_port_pkg::DATA_W-1:0] data_out,
    input  wire logic [host_port_pkg::DATA_W-1:0] data_oe,
    output logic                                  cs_n,
    output logic                                  rd_n,
    output logic                                  wr_n,
    output logic                                  cmd_sel,
    output logic                                  serial_mode,
    output logic                                  status_kind_select,
    output logic      [host_port_pkg::TEST_W-1:0] factory_test_in,
    output logic      [host_port_pkg::DATA_W-1:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [host_port_pkg::DATA_W-1:0] host_en;
    logic [host_port_pkg::DATA_W-1:0] host_val;
    logic [host_port_pkg::DATA_W-1:0] float_pat;

    // idle pins at time zero; test pins stay low for the whole run
    initial begin
        cs_n               = 1'b1;
        rd_n               = 1'b1;
        wr_n               = 1'b1;
        cmd_sel            = 1'b0;
        serial_mode        = 1'b0;
        status_kind_select = 1'b0;
        factory_test_in    = 4'h0;
        host_en            = 8'h00;
        host_val           = 8'h00;
        float_pat          = 8'h5a;
    end

    // undriven bits toggle every cycle so a stale value never passes
    always @(posedge ref_clk) float_pat <= ~float_pat;

    // resolved level of the shared data pins
    assign data_in = (data_oe & data_out) | (~data_oe & host_en & host_val)
                   | (~data_oe & ~host_en & float_pat);

    // one byte per write strobe, data held before and after it
    task write_byte(input logic sub, input logic [7:0] val, input logic csn);
        @(posedge ref_clk);
        cs_n     <= csn;
        cmd_sel  <= sub;
        host_en  <= 8'hff;
        host_val <= val;
        @(posedge ref_clk);
        wr_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cs_n    <= 1'b1;
        host_en <= 8'h00;
        repeat (3) @(posedge ref_clk);
    endtask : write_byte

    // read strobe and chip select levels, then time for the pins to settle
    task set_read(input logic rd, input logic csn);
        @(posedge ref_clk);
        cs_n <= csn;
        rd_n <= rd;
        repeat (4) @(posedge ref_clk);
    endtask : set_read

    // interface mode, status kind and, in serial mode only, bank select on data bit 4
    task set_mode(input logic serial, input logic kind, input logic bank);
        @(posedge ref_clk);
        serial_mode        <= serial;
        status_kind_select <= kind;
        host_en            <= serial ? 8'hf0 : 8'h00;
        host_val           <= {3'b000, bank, 4'h0};
        repeat (4) @(posedge ref_clk);
    endtask : set_mode
endmodule : host_cpu_model

// ===== host_port_pkg.sv
package host_port_pkg;

    // widths of the host, device and apb sides
    localparam int DATA_W     = 8;
    localparam int CHANNELS   = 8;
    localparam int BANK_W     = 4;
    localparam int TEST_W     = 4;
    localparam int AUDIO_W    = 14;
    localparam int APB_AW     = 8;
    localparam int APB_DW     = 32;

    // register byte offsets on the apb side
    localparam logic [APB_AW-1:0] BUSY_OFS      = 8'h00;
    localparam logic [APB_AW-1:0] NOT_READY_OFS = 8'h04;
    localparam logic [APB_AW-1:0] COMMAND_OFS   = 8'h08;
    localparam logic [APB_AW-1:0] FLAG_CLR_OFS  = 8'h0c;
    localparam logic [APB_AW-1:0] AUDIO_OFS     = 8'h10;
    localparam logic [APB_AW-1:0] PIN_STATE_OFS = 8'h14;

    // field positions inside the registers
    localparam int CMD_LSB       = 0;
    localparam int SUB_LSB       = 8;
    localparam int CMD_NEW_BIT   = 16;
    localparam int SUB_NEW_BIT   = 17;
    localparam int AUDIO_L_LSB   = 0;
    localparam int AUDIO_R_LSB   = 16;
    localparam int PIN_SERIAL    = 0;
    localparam int PIN_KIND      = 1;
    localparam int PIN_BANK      = 2;
    localparam int PIN_TEST_LSB  = 4;
    localparam int BANK_BIT      = 4;

    // reset values and enables
    localparam logic [DATA_W-1:0]   BYTE_RST   = 8'h00;
    localparam logic [AUDIO_W-1:0]  AUDIO_GND  = 14'h0000;
    localparam logic [DATA_W-1:0]   OE_NONE    = 8'h00;
    localparam logic [DATA_W-1:0]   OE_ALL     = 8'hff;
    localparam logic [DATA_W-1:0]   OE_SERIAL  = 8'h0f;
    localparam logic [APB_DW-1:0]   WORD_ZERO  = 32'h0000_0000;

    // synchronised host pins travel together
    typedef struct packed {
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic              cmd_sel;
        logic              serial_mode;
        logic              kind_sel;
        logic [TEST_W-1:0] test;
        logic [DATA_W-1:0] data;
    } host_pins_s;

    localparam int PINS_W = $bits(host_pins_s);

    // captured command bytes and their arrival flags
    typedef struct packed {
        logic [DATA_W-1:0] cmd_byte;
        logic [DATA_W-1:0] sub_byte;
        logic              cmd_new;
        logic              sub_new;
    } command_s;

    // write strobe tracking
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_HOLD = 1'b1
    } wr_state_e;

endpackage : host_port_pkg

// ===== host_port_status_select.sv
// Overview of operation
// (RULE1) parallel mode: data pins are latched as command input while write strobe low
// (RULE2) parallel mode: status driven on data pins only while read strobe low
// (RULE3) serial mode: data bit 4 selects bank, bits 3..0 output four channel statuses
// (RULE4) bank select high: channels 8..5 appear on status outputs 3..0
// (RULE5) bank select low: channels 4..1 appear on status outputs 3..0
// (RULE6) kind select high reports not-ready status, low reports busy status
// (RULE7) reset low clears all state, stops oscillator, grounds both audio outputs
// (RULE8) outside party keeps all four factory test inputs low
// (RULE9) host drives interface select high for serial, low for parallel
// (RULE10) strobes are ignored while chip select is high
// (RULE11) written byte is a subcommand with command select high, else a command
// (RULE12) without read strobe in parallel mode the data pins are released
//
// Chosen here: register access over APB and the address map.
module host_port_status_select (
    input  wire logic                                 ref_clk,
    input  wire logic                                 resetn,
    // host pins
    input  wire logic                                 cs_n,
    input  wire logic                                 rd_n,
    input  wire logic                                 wr_n,
    input  wire logic                                 cmd_sel,
    input  wire logic                                 serial_mode,
    input  wire logic                                 status_kind_select,
    input  wire logic [host_port_pkg::TEST_W-1:0]     factory_test_in,
    input  wire logic [host_port_pkg::DATA_W-1:0]     data_in,
    output logic      [host_port_pkg::DATA_W-1:0]     data_out,
    output logic      [host_port_pkg::DATA_W-1:0]     data_oe,
    // device side
    output logic                                      osc_enable,
    output logic      [host_port_pkg::AUDIO_W-1:0]    audio_left,
    output logic      [host_port_pkg::AUDIO_W-1:0]    audio_right,
    // apb slave
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [host_port_pkg::APB_AW-1:0]     paddr,
    input  wire logic [host_port_pkg::APB_DW-1:0]     pwdata,
    output logic      [host_port_pkg::APB_DW-1:0]     prdata,
    output logic                                      pready,
    output logic                                      pslverr
);

    host_port_pkg::host_pins_s              pins_raw;
    host_port_pkg::host_pins_s              pins_q;
    host_port_pkg::command_s                cmd;
    host_port_pkg::wr_state_e               wr_state;
    host_port_pkg::wr_state_e               next_wr_state;
    logic [host_port_pkg::CHANNELS-1:0]     busy;
    logic [host_port_pkg::CHANNELS-1:0]     not_ready;
    logic [host_port_pkg::CHANNELS-1:0]     status_sel;
    logic [host_port_pkg::BANK_W-1:0]       bank_status;
    logic                                   bank_select;
    logic                                   wr_active;
    logic                                   rd_active;
    logic                                   par_read;
    logic                                   wr_done;
    logic                                   apb_write;
    logic                                   apb_setup;
    logic                                   addr_ok;
    logic                                   clr_cmd;
    logic                                   clr_sub;
    logic [host_port_pkg::APB_DW-1:0]       next_prdata;

    // gather the pins for synchronisation
    always_comb begin
        pins_raw.cs_n        = cs_n;
        pins_raw.rd_n        = rd_n;
        pins_raw.wr_n        = wr_n;
        pins_raw.cmd_sel     = cmd_sel;
        pins_raw.serial_mode = serial_mode;
        pins_raw.kind_sel    = status_kind_select;
        pins_raw.test        = factory_test_in;
        pins_raw.data        = data_in;
    end

    // all host pins pass two flops; strobes idle high
    pin_sync #(
        .WIDTH (host_port_pkg::PINS_W),
        .INIT  ({3'b111, {(host_port_pkg::PINS_W-3){1'b0}}})
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (pins_raw),
        .sync_out (pins_q)
    );

    // strobe qualification by mode and chip select
    assign wr_active = !pins_q.serial_mode && !pins_q.cs_n && !pins_q.wr_n;  // RULE10
    assign rd_active = !pins_q.cs_n && !pins_q.rd_n;                          // RULE10
    assign par_read  = !pins_q.serial_mode && rd_active;
    assign wr_done   = (wr_state == host_port_pkg::WR_HOLD) && !wr_active;

    // status kind: not-ready when select high, busy when low
    assign status_sel  = pins_q.kind_sel ? not_ready : busy;                  // RULE6
    assign bank_select = pins_q.data[host_port_pkg::BANK_BIT];                // RULE3
    assign bank_status = bank_select ?
                         status_sel[host_port_pkg::CHANNELS-1:host_port_pkg::BANK_W] :  // RULE4
                         status_sel[host_port_pkg::BANK_W-1:0];                          // RULE5

    // write strobe tracking
    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            host_port_pkg::WR_IDLE: begin
                if (wr_active) begin
                    next_wr_state = host_port_pkg::WR_HOLD;
                end
            end
            host_port_pkg::WR_HOLD: begin
                if (!wr_active) begin
                    next_wr_state = host_port_pkg::WR_IDLE;
                end
            end
            default: begin
                next_wr_state = host_port_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_state <= host_port_pkg::WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    // data latched while write strobe is low, steered by command select
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd.cmd_byte <= host_port_pkg::BYTE_RST;                          // RULE7
            cmd.sub_byte <= host_port_pkg::BYTE_RST;
        end else if (wr_active) begin                                         // RULE1
            if (pins_q.cmd_sel) begin
                cmd.sub_byte <= pins_q.data;                                  // RULE11
            end else begin
                cmd.cmd_byte <= pins_q.data;                                  // RULE11
            end
        end
    end

    // arrival flags set at strobe release; set wins over clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cmd.cmd_new <= 1'b0;
            cmd.sub_new <= 1'b0;
        end else begin
            cmd.cmd_new <= (cmd.cmd_new && !clr_cmd) || (wr_done && !pins_q.cmd_sel);
            cmd.sub_new <= (cmd.sub_new && !clr_sub) || (wr_done && pins_q.cmd_sel);
        end
    end

    // data pin driver: parallel read, serial status nibble, or released
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= host_port_pkg::BYTE_RST;
            data_oe  <= host_port_pkg::OE_NONE;
        end else if (pins_q.serial_mode) begin
            data_out <= {{(host_port_pkg::DATA_W-host_port_pkg::BANK_W){1'b0}}, bank_status};
            data_oe  <= host_port_pkg::OE_SERIAL;                             // RULE3
        end else if (par_read) begin
            data_out <= status_sel;                                           // RULE2
            data_oe  <= host_port_pkg::OE_ALL;                                // RULE2
        end else begin
            data_out <= host_port_pkg::BYTE_RST;
            data_oe  <= host_port_pkg::OE_NONE;                               // RULE12
        end
    end

    // oscillator held stopped while reset is low
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_enable <= 1'b0;                                               // RULE7
        end else begin
            osc_enable <= 1'b1;
        end
    end

    // apb decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign addr_ok   = (paddr == host_port_pkg::BUSY_OFS) ||
                       (paddr == host_port_pkg::NOT_READY_OFS) ||
                       (paddr == host_port_pkg::COMMAND_OFS) ||
                       (paddr == host_port_pkg::FLAG_CLR_OFS) ||
                       (paddr == host_port_pkg::AUDIO_OFS) ||
                       (paddr == host_port_pkg::PIN_STATE_OFS);
    assign clr_cmd   = apb_write && (paddr == host_port_pkg::FLAG_CLR_OFS) &&
                       pwdata[host_port_pkg::CMD_NEW_BIT];
    assign clr_sub   = apb_write && (paddr == host_port_pkg::FLAG_CLR_OFS) &&
                       pwdata[host_port_pkg::SUB_NEW_BIT];

    // channel status and audio levels written by software
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy        <= '0;                                                // RULE7
            not_ready   <= '0;
            audio_left  <= host_port_pkg::AUDIO_GND;                          // RULE7
            audio_right <= host_port_pkg::AUDIO_GND;
        end else if (apb_write) begin
            case (paddr)
                host_port_pkg::BUSY_OFS: begin
                    busy <= pwdata[host_port_pkg::CHANNELS-1:0];
                end
                host_port_pkg::NOT_READY_OFS: begin
                    not_ready <= pwdata[host_port_pkg::CHANNELS-1:0];
                end
                host_port_pkg::AUDIO_OFS: begin
                    audio_left  <= pwdata[host_port_pkg::AUDIO_L_LSB +: host_port_pkg::AUDIO_W];
                    audio_right <= pwdata[host_port_pkg::AUDIO_R_LSB +: host_port_pkg::AUDIO_W];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux
    always_comb begin
        next_prdata = host_port_pkg::WORD_ZERO;
        case (paddr)
            host_port_pkg::BUSY_OFS: begin
                next_prdata[host_port_pkg::CHANNELS-1:0] = busy;
            end
            host_port_pkg::NOT_READY_OFS: begin
                next_prdata[host_port_pkg::CHANNELS-1:0] = not_ready;
            end
            host_port_pkg::COMMAND_OFS: begin
                next_prdata[host_port_pkg::CMD_LSB +: host_port_pkg::DATA_W] = cmd.cmd_byte;
                next_prdata[host_port_pkg::SUB_LSB +: host_port_pkg::DATA_W] = cmd.sub_byte;
                next_prdata[host_port_pkg::CMD_NEW_BIT] = cmd.cmd_new;
                next_prdata[host_port_pkg::SUB_NEW_BIT] = cmd.sub_new;
            end
            host_port_pkg::AUDIO_OFS: begin
                next_prdata[host_port_pkg::AUDIO_L_LSB +: host_port_pkg::AUDIO_W] = audio_left;
                next_prdata[host_port_pkg::AUDIO_R_LSB +: host_port_pkg::AUDIO_W] = audio_right;
            end
            host_port_pkg::PIN_STATE_OFS: begin
                next_prdata[host_port_pkg::PIN_SERIAL] = pins_q.serial_mode;
                next_prdata[host_port_pkg::PIN_KIND]   = pins_q.kind_sel;
                next_prdata[host_port_pkg::PIN_BANK]   = bank_select;
                next_prdata[host_port_pkg::PIN_TEST_LSB +: host_port_pkg::TEST_W] = pins_q.test;
            end
            default: begin
                next_prdata = host_port_pkg::WORD_ZERO;
            end
        endcase
    end

    // answer one cycle after setup: pready, read data and error from flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= host_port_pkg::WORD_ZERO;
        end else if (apb_setup) begin
            pready  <= 1'b1;
            pslverr <= !addr_ok;
            prdata  <= (pwrite || !addr_ok) ? host_port_pkg::WORD_ZERO : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_cmd_capture: assert property (wr_active && !pins_q.cmd_sel |=> // RULE1
        cmd.cmd_byte == $past(pins_q.data))
        else $error("command byte not latched during write strobe");

    chk_sub_capture: assert property (wr_active && pins_q.cmd_sel |=> // RULE11
        cmd.sub_byte == $past(pins_q.data) && $stable(cmd.cmd_byte))
        else $error("subcommand byte not latched or command disturbed");

    chk_read_drive: assert property (par_read |=> // RULE2
        data_oe == host_port_pkg::OE_ALL && data_out == $past(status_sel))
        else $error("status not driven during read strobe");

    chk_bus_release: assert property (!pins_q.serial_mode && !rd_active |=> // RULE12
        data_oe == host_port_pkg::OE_NONE)
        else $error("data pins not released without read strobe");

    chk_chip_ignore: assert property (pins_q.cs_n |=> // RULE10
        $stable(cmd.cmd_byte) && $stable(cmd.sub_byte) && data_oe != host_port_pkg::OE_ALL)
        else $error("strobe acted while chip select high");

    chk_bank_high: assert property (pins_q.serial_mode && bank_select |=> // RULE4
        data_oe == host_port_pkg::OE_SERIAL &&
        data_out[host_port_pkg::BANK_W-1:0] ==
        $past(status_sel[host_port_pkg::CHANNELS-1:host_port_pkg::BANK_W]))
        else $error("upper channel bank not on status outputs");

    chk_bank_low: assert property (pins_q.serial_mode && !bank_select |=> // RULE5
        data_out[host_port_pkg::BANK_W-1:0] == $past(status_sel[host_port_pkg::BANK_W-1:0]))
        else $error("lower channel bank not on status outputs");

    chk_kind_select: assert property (par_read && pins_q.kind_sel |=> // RULE6
        data_out == $past(not_ready))
        else $error("not-ready status not reported with kind select high");

    chk_osc_reset: assert property ($rose(osc_enable) |-> // RULE7
        $past(audio_left) == host_port_pkg::AUDIO_GND &&
        $past(audio_right) == host_port_pkg::AUDIO_GND)
        else $error("audio outputs not grounded at reset release");

    cov_par_read: cover property (par_read ##1 data_oe == host_port_pkg::OE_ALL);
    cov_cmd_write: cover property (wr_active && !pins_q.cmd_sel ##[1:8] cmd.cmd_new);
    cov_sub_write: cover property (wr_active && pins_q.cmd_sel ##[1:8] cmd.sub_new);
    cov_serial_high: cover property (pins_q.serial_mode && bank_select);

endmodule : host_port_status_select

// ===== pin_sync.sv
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // two flops; the first is read only by the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage1   <= INIT;
            sync_out <= INIT;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : pin_sync

// ===== test_host_port_status_select.sv
module test_host_port_status_select;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, resetn, cs_n, rd_n, wr_n, cmd_sel, serial_mode, kind;
    logic        psel, penable, pwrite, pready, pslverr, osc_enable;
    logic [3:0]  test_in;
    logic [7:0]  data_in, data_out, data_oe, paddr;
    logic [13:0] audio_left, audio_right;
    logic [31:0] pwdata, prdata, rd_word;
    logic        rd_err;
    int          err_total, checked;

    host_port_status_select u_host_port_status_select (
        .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .cmd_sel(cmd_sel), .serial_mode(serial_mode), .status_kind_select(kind),
        .factory_test_in(test_in), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .osc_enable(osc_enable), .audio_left(audio_left),
        .audio_right(audio_right), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    host_cpu_model u_host_cpu_model (
        .ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .cmd_sel(cmd_sel), .serial_mode(serial_mode),
        .status_kind_select(kind), .factory_test_in(test_in), .data_in(data_in));

    // clock generation
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer: setup, then access until pready
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= addr; pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            err_total++;
            test_done();
        end
        rd_word = prdata;
        rd_err  = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // command and subcommand capture, flag clear, strobe ignored without chip select
    task t_write();
        u_host_cpu_model.write_byte(1'b0, 8'ha5, 1'b0);
        u_host_cpu_model.write_byte(1'b1, 8'h3c, 1'b0);
        apb(1'b0, host_port_pkg::COMMAND_OFS, 32'h0);
        check(rd_word, 32'h0003_3ca5);
        apb(1'b1, host_port_pkg::FLAG_CLR_OFS, 32'h0003_0000);
        u_host_cpu_model.write_byte(1'b0, 8'h11, 1'b1);
        apb(1'b0, host_port_pkg::COMMAND_OFS, 32'h0);
        check(rd_word, 32'h0000_3ca5);
        $display("write test done");
    endtask : t_write

    // parallel status read of both kinds, release, chip select gating
    task t_read();
        apb(1'b1, host_port_pkg::BUSY_OFS, 32'h96);
        apb(1'b1, host_port_pkg::NOT_READY_OFS, 32'h4b);
        u_host_cpu_model.set_read(1'b0, 1'b0);
        check({24'h0, data_oe}, 32'hff);
        check({24'h0, data_out}, 32'h96);
        u_host_cpu_model.set_mode(1'b0, 1'b1, 1'b0);
        check({24'h0, data_out}, 32'h4b);
        u_host_cpu_model.set_read(1'b1, 1'b0);
        check({24'h0, data_oe}, 32'h00);
        u_host_cpu_model.set_read(1'b0, 1'b1);
        check({24'h0, data_oe}, 32'h00);
        u_host_cpu_model.set_read(1'b1, 1'b1);
        $display("read test done");
    endtask : t_read

    // serial status outputs for every kind and bank
    task t_serial();
        logic [7:0] src;
        logic [3:0] exp;
        for (int i = 0; i < 4; i++) begin
            u_host_cpu_model.set_mode(1'b1, i[1], i[0]);
            src = i[1] ? 8'h4b : 8'h96;
            exp = i[0] ? src[7:4] : src[3:0];
            check({24'h0, data_oe}, 32'h0f);
            check({24'h0, data_out}, {28'h0, exp});
            apb(1'b0, host_port_pkg::PIN_STATE_OFS, 32'h0);
            check(rd_word, {29'h0, i[0], i[1], 1'b1});
        end
        u_host_cpu_model.set_mode(1'b0, 1'b0, 1'b0);
        $display("serial test done");
    endtask : t_serial

    // audio register, unmapped address, then reset in mid-run
    task t_reset();
        apb(1'b1, host_port_pkg::AUDIO_OFS, 32'h1234_0abc);
        // the write lands at the edge that ends the access; let it settle
        @(posedge ref_clk);
        check({18'h0, audio_left}, 32'h0abc);
        check({18'h0, audio_right}, 32'h1234);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        check(rd_word, 32'h0);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({31'h0, osc_enable}, 32'h0);
        check({4'h0, audio_left, 4'h0, audio_right}, 32'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({31'h0, osc_enable}, 32'h1);
        apb(1'b0, host_port_pkg::COMMAND_OFS, 32'h0);
        check(rd_word, 32'h0);
        apb(1'b0, host_port_pkg::BUSY_OFS, 32'h0);
        check(rd_word, 32'h0);
        $display("reset test done");
    endtask : t_reset

    // watchdog
    initial begin
        #400000;
        err_total++;
        test_done();
    end

    // main sequence
    initial begin
        err_total = 0;
        checked   = 0;
        resetn    = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        t_write();
        t_read();
        t_serial();
        t_reset();
        test_done();
    end
endmodule : test_host_port_status_select
